// File: common/serial_port_consts.vh
// Constants for the serial configuration port and its register bank.
// Assumes inclusion by bare name from design files; definitions only.
//
// Operation
// - Seven low address bits pick the register written or read.
// - Device captures sixteen data bits on rising serial clock edges.
// - Flag high makes a readback; writes stay blocked until flag cleared.
// - Readback shifts sixteen register bits out, MSB first, on chosen pin.
// - Transfers with the flag cleared make the device accept writes again.
// - One write updates every field of the addressed register together.
// - Register 0 bit 15 picks three-wire (0) or four-wire (1) mode.
// - Register 0 bit 14 enables two-times decimation filter, default off.
// - Register 0 bit 12 picks filter band, low or high pass.
// - Register 1 bit 15 enables automatic gain and offset correction.
// - Flag latched on first rising clock edge after select falls.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

`define ADDR_BITS 8
`define DATA_BITS 16
`define FRAME_BITS 24
`define RW_FLAG_BIT 7
`define REG_ADDR_W 7

`define REG_IF_FILTER 7'h00
`define REG_CORR_FMT 7'h01
`define REG_OVR_THRESH 7'h02
`define REG_CORR_START 7'h03
`define REG_SYNC_LOW 7'h0e
`define REG_SYNC_VREF 7'h0f
`define REG_TEMP 7'h2b
`define REG_SOFT_RESET 7'h2c
`define REG_SLEEP 7'h37
`define REG_POWER 7'h38
`define REG_DRIVER 7'h3a
`define REG_BUS_EN 7'h66

`define RST_IF_FILTER 16'h0000
`define RST_CORR_FMT 16'h0000
`define RST_OVR_THRESH 16'h0780
`define RST_CORR_START 16'h4b18
`define RST_SYNC_LOW 16'haaa8
`define RST_SYNC_VREF 16'ha000
`define RST_SOFT_RESET 16'h0000
`define RST_SLEEP 16'h0000
`define RST_POWER 16'hffff
`define RST_DRIVER 16'h0000
`define RST_BUS_EN 16'h0000
`define SOFT_RESET_KEY 16'hd2f0

`define BIT_WIRE_MODE 15
`define BIT_DECIM_EN 14
`define BIT_FILTER_BAND 12
`define BIT_CORR_EN 15

`define CNT_W 5
`define CNT_ZERO 5'h00
`define CNT_ADDR_DONE 5'h08
`define CNT_FRAME_DONE 5'h18

`endif

// File: design/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes nothing but the local clock and reset.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pin_sync
`default_nettype wire

// File: design/reg_bank.v
// Register bank: writable words, soft reset key, registered read data.
// Assumes write strobes come from the serial port on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"
module reg_bank (
    input wire clk,
    input wire sys_rst,
    input wire wr_en,
    input wire [`REG_ADDR_W-1:0] addr,
    input wire [`DATA_BITS-1:0] wr_data,
    input wire [8:0] temp_value,
    output reg [`DATA_BITS-1:0] rd_data,
    output wire [`DATA_BITS-1:0] if_filter,
    output wire [`DATA_BITS-1:0] corr_fmt
);
    reg [`DATA_BITS-1:0] r_if, r_corr, r_ovr, r_cstart, r_sync_lo, r_sync_vr;
    reg [`DATA_BITS-1:0] r_sleep, r_power, r_drv, r_bus;
    wire soft_rst;

    // Key write restores defaults; the key itself never sticks, reading 0
    assign soft_rst = wr_en && addr == `REG_SOFT_RESET && wr_data == `SOFT_RESET_KEY;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_if <= `RST_IF_FILTER;
            r_corr <= `RST_CORR_FMT;
            r_ovr <= `RST_OVR_THRESH;
            r_cstart <= `RST_CORR_START;
            r_sync_lo <= `RST_SYNC_LOW;
            r_sync_vr <= `RST_SYNC_VREF;
            r_sleep <= `RST_SLEEP;
            r_power <= `RST_POWER;
            r_drv <= `RST_DRIVER;
            r_bus <= `RST_BUS_EN;
        end else if (soft_rst) begin
            r_if <= `RST_IF_FILTER;
            r_corr <= `RST_CORR_FMT;
            r_ovr <= `RST_OVR_THRESH;
            r_cstart <= `RST_CORR_START;
            r_sync_lo <= `RST_SYNC_LOW;
            r_sync_vr <= `RST_SYNC_VREF;
            r_sleep <= `RST_SLEEP;
            r_power <= `RST_POWER;
            r_drv <= `RST_DRIVER;
            r_bus <= `RST_BUS_EN;
        end else if (wr_en) begin
            // Whole word at once
            case (addr)
                `REG_IF_FILTER: r_if <= wr_data;
                `REG_CORR_FMT: r_corr <= wr_data;
                `REG_OVR_THRESH: r_ovr <= wr_data;
                `REG_CORR_START: r_cstart <= wr_data;
                `REG_SYNC_LOW: r_sync_lo <= wr_data;
                `REG_SYNC_VREF: r_sync_vr <= wr_data;
                `REG_SLEEP: r_sleep <= wr_data;
                `REG_POWER: r_power <= wr_data;
                `REG_DRIVER: r_drv <= wr_data;
                `REG_BUS_EN: r_bus <= wr_data;
                default: r_if <= r_if;
            endcase
        end
    end

    // Read data is registered every cycle from the current address
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 16'h0000;
        end else begin
            case (addr)
                `REG_IF_FILTER: rd_data <= r_if;
                `REG_CORR_FMT: rd_data <= r_corr;
                `REG_OVR_THRESH: rd_data <= r_ovr;
                `REG_CORR_START: rd_data <= r_cstart;
                `REG_SYNC_LOW: rd_data <= r_sync_lo;
                `REG_SYNC_VREF: rd_data <= r_sync_vr;
                `REG_TEMP: rd_data <= {7'h00, temp_value};
                `REG_SLEEP: rd_data <= r_sleep;
                `REG_POWER: rd_data <= r_power;
                `REG_DRIVER: rd_data <= r_drv;
                `REG_BUS_EN: rd_data <= r_bus;
                default: rd_data <= 16'h0000;
            endcase
        end
    end

    assign if_filter = r_if;
    assign corr_fmt = r_corr;
endmodule // reg_bank
`default_nettype wire

// File: design/serial_config_port.v
// Serial configuration port: three/four-wire slave in front of the register bank.
// Assumes serial clock far slower than clk (20 MHz max vs 100 MHz); all link
// pins are sampled through two flip-flops before use.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"
module serial_config_port (
    input wire clk,
    input wire sys_rst,
    input wire serial_clk,
    input wire serial_select_n,
    input wire serial_data_in,
    output reg serial_data_out,
    output reg serial_data_oe_n,
    output reg serial_out_pin,
    output reg serial_out_oe_n,
    input wire [8:0] temp_value,
    output reg four_wire_mode,
    output reg decimation_enable,
    output reg filter_band_select,
    output reg auto_correction_enable,
    output reg write_blocked
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ADDR = 4'b0010;
    localparam [3:0] ST_DATA = 4'b0100;
    localparam [3:0] ST_WAIT = 4'b1000;

    wire [2:0] pins_sync;
    wire sclk_s;
    wire sel_n_s;
    wire din_s;
    reg sclk_d;
    reg [3:0] state;
    reg [`CNT_W-1:0] bit_cnt;
    reg [`ADDR_BITS-1:0] addr_sh;
    reg [`DATA_BITS-1:0] data_sh;
    reg [`DATA_BITS-1:0] out_sh;
    reg read_cycle;
    reg rd_phase;
    reg wr_en;
    reg load_pending;
    reg load_go;
    wire sclk_rise;
    wire sclk_fall;
    wire [`DATA_BITS-1:0] rd_data;
    wire [`DATA_BITS-1:0] if_filter;
    wire [`DATA_BITS-1:0] corr_fmt;
    wire [`REG_ADDR_W-1:0] bank_addr;

    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'b010)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({serial_clk, serial_select_n, serial_data_in}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign sel_n_s = pins_sync[1];
    assign din_s = pins_sync[0];
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign bank_addr = addr_sh[`REG_ADDR_W-1:0];

    reg_bank u_bank (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en),
        .addr(bank_addr),
        .wr_data(data_sh),
        .temp_value(temp_value),
        .rd_data(rd_data),
        .if_filter(if_filter),
        .corr_fmt(corr_fmt)
    );

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // Select high aborts any frame, so a short frame never writes.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            bit_cnt <= `CNT_ZERO;
            addr_sh <= 8'h00;
            data_sh <= 16'h0000;
            read_cycle <= 1'b0;
            rd_phase <= 1'b0;
            wr_en <= 1'b0;
            load_pending <= 1'b0;
            load_go <= 1'b0;
            write_blocked <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            load_pending <= 1'b0;
            // Read data register needs one clock to follow the completed address
            load_go <= load_pending;
            if (sel_n_s) begin
                state <= ST_IDLE;
                bit_cnt <= `CNT_ZERO;
                rd_phase <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        bit_cnt <= `CNT_ZERO;
                        state <= ST_ADDR;
                    end
                    ST_ADDR: begin
                        if (sclk_rise) begin
                            // MSB first: flag lands in the top bit
                            addr_sh <= {addr_sh[`ADDR_BITS-2:0], din_s};
                            if (bit_cnt == `CNT_ZERO) begin
                                read_cycle <= din_s;
                                write_blocked <= din_s;
                            end
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == `CNT_ADDR_DONE - 5'h01) begin
                                state <= ST_DATA;
                                load_pending <= read_cycle;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (sclk_rise) begin
                            data_sh <= {data_sh[`DATA_BITS-2:0], din_s};
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == `CNT_FRAME_DONE - 5'h01) begin
                                state <= ST_WAIT;
                                wr_en <= !read_cycle;
                            end
                        end
                        rd_phase <= read_cycle;
                    end
                    ST_WAIT: begin
                        state <= ST_WAIT;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Readback shifter
    // ------------------------------------------------------------
    // Bits change on the falling edge so the controller sees them stable
    // at the next rising edge; costs half a clock of setup margin.
    // The fall between the last address edge and the first data edge must
    // not shift, or the top bit would be gone before it is sampled.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_sh <= 16'h0000;
        end else if (load_go) begin
            out_sh <= rd_data;
        end else if (rd_phase && sclk_fall && bit_cnt != `CNT_ADDR_DONE) begin
            out_sh <= {out_sh[`DATA_BITS-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and decoded controls
    // ------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
            serial_out_pin <= 1'b0;
            serial_out_oe_n <= 1'b1;
            four_wire_mode <= 1'b0;
            decimation_enable <= 1'b0;
            filter_band_select <= 1'b0;
            auto_correction_enable <= 1'b0;
        end else begin
            serial_data_out <= out_sh[`DATA_BITS-1];
            serial_out_pin <= out_sh[`DATA_BITS-1];
            // Three-wire: data pin only drives in readback data phase
            serial_data_oe_n <= !(rd_phase && !sel_n_s && !if_filter[`BIT_WIRE_MODE]);
            serial_out_oe_n <= !(rd_phase && !sel_n_s && if_filter[`BIT_WIRE_MODE]);
            four_wire_mode <= if_filter[`BIT_WIRE_MODE];
            decimation_enable <= if_filter[`BIT_DECIM_EN];
            // Band only matters while decimating
            filter_band_select <= if_filter[`BIT_FILTER_BAND] & if_filter[`BIT_DECIM_EN];
            auto_correction_enable <= corr_fmt[`BIT_CORR_EN];
        end
    end
endmodule // serial_config_port
`default_nettype wire

// File: bench/serial_port_sva.sv
// Checker for the serial configuration port, bound to its top module.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module serial_port_sva (
    input wire clk,
    input wire sys_rst,
    input wire serial_select_n,
    input wire serial_data_oe_n,
    input wire serial_out_oe_n,
    input wire four_wire_mode,
    input wire decimation_enable,
    input wire filter_band_select,
    input wire auto_correction_enable,
    input wire write_blocked
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_pins_exclusive: assert property (
        serial_data_oe_n || serial_out_oe_n) else $error("both data pins driven");
    a_three_wire_only: assert property (
        !serial_data_oe_n |-> !four_wire_mode) else $error("data pin driven in four-wire");
    a_four_wire_only: assert property (
        !serial_out_oe_n |-> four_wire_mode) else $error("out pin driven in three-wire");
    a_select_release: assert property (
        serial_select_n [*8] |-> serial_data_oe_n && serial_out_oe_n)
        else $error("pin still driven after frame");
    a_data_in_frame: assert property (
        !serial_data_oe_n |-> !$past(serial_select_n, 6)) else $error("data pin driven idle");
    a_out_in_frame: assert property (
        !serial_out_oe_n |-> !$past(serial_select_n, 6)) else $error("out pin driven idle");
    a_band_needs_decim: assert property (
        filter_band_select |-> decimation_enable) else $error("band without decimation");
    a_blocked_stable: assert property (
        write_blocked && $past(write_blocked) |-> $stable({four_wire_mode, decimation_enable,
        filter_band_select, auto_correction_enable})) else $error("field changed while blocked");
    a_flag_in_frame: assert property (
        $changed(write_blocked) |-> !$past(serial_select_n, 2)) else $error("flag moved idle");
endmodule // serial_port_sva
bind serial_config_port serial_port_sva chk_u (.clk(clk), .sys_rst(sys_rst),
    .serial_select_n(serial_select_n), .serial_data_oe_n(serial_data_oe_n),
    .serial_out_oe_n(serial_out_oe_n), .four_wire_mode(four_wire_mode),
    .decimation_enable(decimation_enable), .filter_band_select(filter_band_select),
    .auto_correction_enable(auto_correction_enable), .write_blocked(write_blocked));
`default_nettype wire

// File: bench/host_ctrl_model.sv
// Model of the external controller that runs the serial link.
// Assumes the bench clock; serial clock idles low and halves last 8 clocks.
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
    input wire clk,
    input wire serial_data_out,
    input wire serial_data_oe_n,
    input wire serial_out_pin,
    input wire serial_out_oe_n,
    output var logic serial_clk,
    output var logic serial_select_n,
    output wire serial_data_in
);
    logic host_en = 1'b0;
    logic host_bit = 1'b0;
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
    end
    // A released line shows the inverse of the last bit so stale data never matches
    assign serial_data_in = !serial_data_oe_n ? serial_data_out : host_en ? host_bit : ~host_bit;
    task xfer(input [7:0] a, input [15:0] d, input integer n, output logic [15:0] q);
        logic [23:0] f;
        integer i;
        begin
            f = {a, d};
            q = 16'h0000;
            @(posedge clk);
            serial_select_n <= 1'b0;
            repeat (3) @(posedge clk);
            for (i = 0; i < n; i++) begin
                host_bit <= f[23-i];
                host_en <= (i < 8) || !a[7];
                serial_clk <= 1'b0;
                repeat (8) @(posedge clk);
                serial_clk <= 1'b1;
                if (i >= 8)
                    q = {q[14:0], !serial_out_oe_n ? serial_out_pin :
                        !serial_data_oe_n ? serial_data_out : 1'bx};
                repeat (8) @(posedge clk);
            end
            serial_clk <= 1'b0;
            repeat (8) @(posedge clk);
            serial_select_n <= 1'b1;
            host_en <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// File: bench/adc_serial_config_port_tb.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model for link traffic and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_config_port_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] temp_value = 9'h000;
    logic [15:0] q;
    integer err_count = 0;
    integer samples_checked = 0;
    wire serial_clk, serial_select_n, serial_data_in, serial_data_out, serial_data_oe_n;
    wire serial_out_pin, serial_out_oe_n, four_wire_mode, decimation_enable;
    wire filter_band_select, auto_correction_enable, write_blocked;
    initial forever #5 clk = ~clk;
    serial_config_port dut_u (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
        .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
        .temp_value(temp_value), .four_wire_mode(four_wire_mode),
        .decimation_enable(decimation_enable), .filter_band_select(filter_band_select),
        .auto_correction_enable(auto_correction_enable), .write_blocked(write_blocked));
    host_ctrl_model host_u (.clk(clk), .serial_data_out(serial_data_out),
        .serial_data_oe_n(serial_data_oe_n), .serial_out_pin(serial_out_pin),
        .serial_out_oe_n(serial_out_oe_n), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n), .serial_data_in(serial_data_in));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input [127:0] nm, input [15:0] exp, input [15:0] got);
        begin
            samples_checked++;
            if (got !== exp) begin
                err_count++;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task flags(input [4:0] exp);
        chk("flags", {11'h000, exp}, {11'h000, four_wire_mode, decimation_enable,
            filter_band_select, auto_correction_enable, write_blocked});
    endtask
    task wr(input [6:0] a, input [15:0] d);
        host_u.xfer({1'b0, a}, d, 24, q);
    endtask
    task rd(input [6:0] a, input [15:0] exp);
        begin
            host_u.xfer({1'b1, a}, 16'h0000, 24, q);
            chk("read", exp, q);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        begin
            flags(5'b00000);
            rd(7'h02, 16'h0780);
            rd(7'h38, 16'hffff);
            flags(5'b00001);
            $display("done reset");
        end
    endtask
    task t_fields;
        begin
            wr(7'h00, 16'h5000);
            flags(5'b01100);
            rd(7'h00, 16'h5000);
            wr(7'h00, 16'h1000);
            flags(5'b00000);
            wr(7'h01, 16'h8000);
            flags(5'b00010);
            $display("done fields");
        end
    endtask
    task t_blocking;
        begin
            rd(7'h01, 16'h8000);
            flags(5'b00011);
            host_u.xfer(8'h01, 16'h0000, 20, q);
            flags(5'b00010);
            wr(7'h01, 16'h0000);
            flags(5'b00000);
            $display("done blocking");
        end
    endtask
    task t_regs;
        begin
            @(posedge clk) temp_value <= 9'h1a5;
            wr(7'h2b, 16'hffff);
            rd(7'h2b, 16'h01a5);
            wr(7'h10, 16'h1234);
            rd(7'h10, 16'h0000);
            wr(7'h03, 16'h0123);
            rd(7'h03, 16'h0123);
            wr(7'h2c, 16'hd2f0);
            rd(7'h03, 16'h4b18);
            rd(7'h2c, 16'h0000);
            $display("done registers");
        end
    endtask
    task t_four;
        begin
            wr(7'h00, 16'h8000);
            flags(5'b10000);
            rd(7'h00, 16'h8000);
            wr(7'h00, 16'h0000);
            flags(5'b00000);
            $display("done four-wire");
        end
    endtask
    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        t_reset;
        t_fields;
        t_blocking;
        t_regs;
        t_four;
        end_of_test;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        end_of_test;
    end
endmodule // adc_serial_config_port_tb
`default_nettype wire
